/* hp_defrost_defines.svh */
// Constants for the heat pump defrost sequencer: offsets, fields, timing
`ifndef HP_DEFROST_DEFINES_SVH
`define HP_DEFROST_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_HZ 200000000
`define SEC_TICK_CYCLES (`CLK_HZ)
`define FROST_TEMP_F 8'sd35
`define FROST_RUN_MIN 34
`define FROST_RUN_S (`FROST_RUN_MIN * 60)
`define SWITCH_HOLD_S 30
`define DEFROST_MAX_MIN 14
`define DEFROST_MAX_S (`DEFROST_MAX_MIN * 60)
`define OIL_RUN_MIN 6
`define OIL_RUN_S (`OIL_RUN_MIN * 60)

// ****************************************
// Termination temperatures, degrees F
// ****************************************
`define TERM_F_OFF_OFF 8'sd60
`define TERM_F_ON_OFF 8'sd50
`define TERM_F_OFF_ON 8'sd40
`define TERM_F_ON_ON 8'sd70

// ****************************************
// Compressor speeds and limiter step
// ****************************************
`define SPD_SWITCH 8'h50
`define SPD_DEFROST 8'hA0
`define SPD_OIL 8'h78
`define SPD_NOMINAL 8'h80
`define SPD_STEP 8'h04
`define SPD_MAX 8'hFF

// ****************************************
// Register offsets and fields
// ****************************************
`define REG_CTRL 12'h000
`define REG_DEMAND 12'h004
`define REG_STATUS 12'h008
`define REG_IRQ_STAT 12'h00C
`define REG_IRQ_MASK 12'h010
`define REG_FROST_TIME 12'h014
`define CTRL_COMM_BIT 0
`define CTRL_HEAT_BIT 1
`define CTRL_COOL_BIT 2
`define CTRL_RST 3'h0
`define DEMAND_RST 8'h00
`define MASK_RST 4'h0
`define EV_DEF_START 0
`define EV_TERM_TEMP 1
`define EV_TERM_TIME 2
`define EV_DIS_LIMIT 3

`endif

/* hp_defrost_pkg.sv */
// Types shared by the defrost sequencer files
`default_nettype none
package hp_defrost_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_PRE = 3'b011,
    ST_DEF = 3'b010,
    ST_POST = 3'b110,
    ST_REC = 3'b111,
    ST_OIL = 3'b101
  } seq_state_t;
  typedef enum logic [1:0] {
    REC_FAN = 2'b00,
    REC_AUX = 2'b01,
    REC_EXV = 2'b11
  } rec_step_t;
endpackage : hp_defrost_pkg
`default_nettype wire

/* discharge_speed_limiter.sv */
// Compressor speed limiter driven by discharge temperature
`timescale 1ns/1ps
`default_nettype none
`include "hp_defrost_defines.svh"
module discharge_speed_limiter
  import hp_defrost_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sec_tick,
  input wire logic discharge_hot,
  input wire logic [7:0] demand,
  output logic [7:0] speed,
  output logic limiting
);
  logic [7:0] limit_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_reg <= `SPD_MAX;
    end else if (sec_tick) begin
      if (discharge_hot) begin
        // Step down from the actual speed, not the old ceiling
        limit_reg <= (speed > `SPD_STEP) ? speed - `SPD_STEP : 8'h00;
      end else if (limit_reg < `SPD_MAX - `SPD_STEP) begin
        limit_reg <= limit_reg + `SPD_STEP;
      end else begin
        limit_reg <= `SPD_MAX;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed <= 8'h00;
    end else begin
      speed <= (demand < limit_reg) ? demand : limit_reg;
    end
  end

  assign limiting = (limit_reg < demand);

  // ****************************************
  // Checks
  // ****************************************
  step_down_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_tick && discharge_hot && speed > `SPD_STEP
    |=> limit_reg == $past(speed) - `SPD_STEP)
    else $error("limit did not step down on hot discharge");
  speed_cap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    speed <= $past(limit_reg))
    else $error("speed above discharge limit");
endmodule : discharge_speed_limiter
`default_nettype wire

/* heat_pump_defrost_sequencer.sv */
// Outdoor unit controller defrost and run sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "hp_defrost_defines.svh"
module heat_pump_defrost_sequencer
  import hp_defrost_pkg::*;
#(
  parameter int SEC_CYCLES = `SEC_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic heat_call_input,
  input wire logic cool_stage_one_input,
  input wire logic cool_stage_two_input,
  input wire logic term_temp_sel_bit0,
  input wire logic term_temp_sel_bit1,
  input wire logic signed [7:0] coil_temp_sensor,
  input wire logic signed [7:0] ambient_temp_sensor,
  input wire logic ambient_sensor_fault,
  input wire logic frost_detected,
  input wire logic discharge_hot,
  input wire logic exv_stepping_open,
  input wire logic exv_stepping_closed,
  input wire logic link_tx_active,
  input wire logic link_rx_active,
  output logic [7:0] comp_speed,
  output logic reversing_valve,
  output logic outdoor_fan_on,
  output logic exv_full_open,
  output logic aux_heat_req,
  output logic nominal_airflow_req,
  output logic defrost_active,
  output logic exv_open_led,
  output logic exv_close_led,
  output logic link_tx_indicator,
  output logic link_rx_indicator,
  output logic irq
);
  localparam int SWITCH_S = `SWITCH_HOLD_S;
  localparam int DEF_MAX_S = `DEFROST_MAX_S;
  localparam int OIL_S = `OIL_RUN_S;
  localparam int FROST_S = `FROST_RUN_S;

  function automatic logic signed [7:0] term_temp_f(input logic [1:0] sel);
    case (sel)
      2'b00: term_temp_f = `TERM_F_OFF_OFF;
      2'b01: term_temp_f = `TERM_F_ON_OFF;
      2'b10: term_temp_f = `TERM_F_OFF_ON;
      default: term_temp_f = `TERM_F_ON_ON;
    endcase
  endfunction : term_temp_f

  // ****************************************
  // Pin synchronisers and second tick
  // ****************************************
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [27:0] tick_cnt_reg;
  logic sec_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {term_temp_sel_bit1, term_temp_sel_bit0,
                       cool_stage_two_input, cool_stage_one_input,
                       heat_call_input};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 28'h0000000;
    end else if (tick_cnt_reg == 28'(SEC_CYCLES - 1)) begin
      tick_cnt_reg <= 28'h0000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 28'h0000001;
    end
  end
  assign sec_tick = (tick_cnt_reg == 28'(SEC_CYCLES - 1));

  // ****************************************
  // Register file
  // ****************************************
  logic [2:0] ctrl_reg;
  logic [7:0] demand_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] events;
  seq_state_t state_reg;
  logic [11:0] frost_cnt_reg;
  logic limiting;
  logic wr_en;
  logic signed [7:0] term_temp;
  logic conv_mode;
  logic heat_call;
  logic cool_call;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign term_temp = term_temp_f(pin_sync_reg[4:3]);
  assign conv_mode = !ctrl_reg[`CTRL_COMM_BIT];
  // thermostat pins replace the serial demand
  assign heat_call = conv_mode ? pin_sync_reg[0] : ctrl_reg[`CTRL_HEAT_BIT];
  assign cool_call = conv_mode ? (pin_sync_reg[1] || pin_sync_reg[2])
                               : ctrl_reg[`CTRL_COOL_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RST;
      demand_reg <= `DEMAND_RST;
      irq_mask_reg <= `MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        `REG_CTRL: ctrl_reg <= pwdata[2:0];
        `REG_DEMAND: demand_reg <= pwdata[7:0];
        `REG_IRQ_MASK: irq_mask_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // New events win over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 4'h0;
    end else if (wr_en && paddr == `REG_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data latched in the setup cycle so the access phase is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        `REG_CTRL: prdata <= {29'h0, ctrl_reg};
        `REG_DEMAND: prdata <= {24'h0, demand_reg};
        `REG_STATUS: prdata <= {16'h0, term_temp, 2'h0, limiting,
                                defrost_active, 1'b0, state_reg};
        `REG_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
        `REG_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
        `REG_FROST_TIME: prdata <= {20'h0, frost_cnt_reg};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Defrost sequencer
  // ****************************************
  rec_step_t rec_step_reg;
  logic [11:0] sec_cnt_reg;
  logic heating_reg;
  logic defrost_due;
  logic coil_cold;
  logic term_hit;
  logic [7:0] comp_target;

  assign coil_cold = coil_temp_sensor < `FROST_TEMP_F;
  // frost indication waived when ambient sensor failed
  assign defrost_due = coil_cold && frost_cnt_reg >= 12'(FROST_S)
                       && (ambient_sensor_fault || frost_detected);
  assign term_hit = coil_temp_sensor >= term_temp;
  assign defrost_active = (state_reg == ST_DEF);

  // cold-coil heating run time, cleared by each defrost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frost_cnt_reg <= 12'h000;
    end else if (state_reg == ST_DEF) begin
      frost_cnt_reg <= 12'h000;
    end else if (state_reg == ST_RUN && heating_reg && coil_cold
                 && sec_tick && frost_cnt_reg != 12'hFFF) begin
      frost_cnt_reg <= frost_cnt_reg + 12'h001;
    end
  end

  // same path whatever the control source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      rec_step_reg <= REC_FAN;
      sec_cnt_reg <= 12'h000;
      heating_reg <= 1'b0;
      reversing_valve <= 1'b0;
      outdoor_fan_on <= 1'b0;
      exv_full_open <= 1'b0;
      aux_heat_req <= 1'b0;
    end else begin
      if (sec_tick) begin
        sec_cnt_reg <= sec_cnt_reg + 12'h001;
      end
      case (state_reg)
        ST_IDLE: begin
          sec_cnt_reg <= 12'h000;
          if (heat_call || cool_call) begin
            state_reg <= ST_RUN;
            heating_reg <= heat_call;
            reversing_valve <= heat_call;
            outdoor_fan_on <= 1'b1;
          end
        end
        ST_RUN: begin
          sec_cnt_reg <= 12'h000;
          if (heating_reg ? !heat_call : !cool_call) begin
            state_reg <= ST_IDLE;
            reversing_valve <= 1'b0;
            outdoor_fan_on <= 1'b0;
          end else if (heating_reg && defrost_due) begin
            state_reg <= ST_PRE;
          end
        end
        ST_PRE: begin
          // valve off, valve open, fan off after hold
          if (sec_tick && sec_cnt_reg == 12'(SWITCH_S - 1)) begin
            state_reg <= ST_DEF;
            sec_cnt_reg <= 12'h000;
            reversing_valve <= 1'b0;
            exv_full_open <= 1'b1;
            outdoor_fan_on <= 1'b0;
            aux_heat_req <= 1'b1;
          end
        end
        ST_DEF: begin
          if (term_hit || (sec_tick && sec_cnt_reg == 12'(DEF_MAX_S - 1)))
          begin
            state_reg <= ST_POST;
            sec_cnt_reg <= 12'h000;
          end
        end
        ST_POST: begin
          // valve back to heating after hold
          if (sec_tick && sec_cnt_reg == 12'(SWITCH_S - 1)) begin
            state_reg <= ST_REC;
            rec_step_reg <= REC_FAN;
            reversing_valve <= 1'b1;
          end
        end
        ST_REC: begin
          sec_cnt_reg <= 12'h000;
          // one step per clock, fixed order
          case (rec_step_reg)
            REC_FAN: begin
              outdoor_fan_on <= 1'b1;
              rec_step_reg <= REC_AUX;
            end
            REC_AUX: begin
              aux_heat_req <= 1'b0;
              rec_step_reg <= REC_EXV;
            end
            default: begin
              exv_full_open <= 1'b0;
              state_reg <= ST_OIL;
            end
          endcase
        end
        ST_OIL: begin
          // oil return run then normal heating
          if (sec_tick && sec_cnt_reg == 12'(OIL_S - 1)) begin
            state_reg <= ST_RUN;
            sec_cnt_reg <= 12'h000;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign events[`EV_DEF_START] = (state_reg == ST_PRE) && sec_tick
                                 && sec_cnt_reg == 12'(SWITCH_S - 1);
  assign events[`EV_TERM_TEMP] = defrost_active && term_hit;
  assign events[`EV_TERM_TIME] = defrost_active && !term_hit && sec_tick
                                 && sec_cnt_reg == 12'(DEF_MAX_S - 1);
  assign events[`EV_DIS_LIMIT] = limiting && discharge_hot && sec_tick;

  always_comb begin
    case (state_reg)
      ST_RUN: comp_target = conv_mode ? `SPD_NOMINAL : demand_reg;
      ST_PRE, ST_POST, ST_REC: comp_target = `SPD_SWITCH;
      ST_DEF: comp_target = `SPD_DEFROST;
      ST_OIL: comp_target = `SPD_OIL;
      default: comp_target = 8'h00;
    endcase
  end

  discharge_speed_limiter u_limiter (
    .pclk(pclk),
    .presetn(presetn),
    .sec_tick(sec_tick),
    .discharge_hot(discharge_hot),
    .demand(comp_target),
    .speed(comp_speed),
    .limiting(limiting)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nominal_airflow_req <= 1'b0;
      exv_open_led <= 1'b0;
      exv_close_led <= 1'b0;
      link_tx_indicator <= 1'b0;
      link_rx_indicator <= 1'b0;
    end else begin
      nominal_airflow_req <= conv_mode && state_reg == ST_RUN;
      exv_open_led <= exv_stepping_open;
      exv_close_led <= exv_stepping_closed;
      link_tx_indicator <= link_tx_active;
      link_rx_indicator <= link_rx_active;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  pre_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(defrost_active) |-> $past(state_reg) == ST_PRE
    && !reversing_valve && exv_full_open && !outdoor_fan_on)
    else $error("defrost entered without full hold or outputs");
  aux_heat_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    defrost_active |-> aux_heat_req)
    else $error("no supplemental heat in defrost");
  def_speed_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    defrost_active && $past(defrost_active) && !$past(limiting)
    |-> comp_speed == `SPD_DEFROST)
    else $error("defrost speed wrong");
  term_exit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    defrost_active && term_hit |=> state_reg == ST_POST)
    else $error("defrost did not end at temperature");
  def_limit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    defrost_active |-> sec_cnt_reg < 12'(DEF_MAX_S))
    else $error("defrost ran past time limit");
  decode_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_sync_reg[4:3] == 2'b10 |-> term_temp == 8'sd40)
    else $error("termination decode wrong");
  rev_return_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_POST ##1 state_reg == ST_REC
    |-> $past(sec_cnt_reg, 1) == 12'(SWITCH_S - 1) && reversing_valve)
    else $error("valve returned early");
  rec_order_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(reversing_valve) && state_reg == ST_REC
    |-> !outdoor_fan_on ##1 outdoor_fan_on && aux_heat_req
    ##1 !aux_heat_req && exv_full_open ##1 !exv_full_open)
    else $error("recovery order wrong");
  oil_speed_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_OIL && $past(state_reg) == ST_OIL && !$past(limiting)
    |-> comp_speed == `SPD_OIL)
    else $error("oil speed wrong");
  fallback_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_RUN && heating_reg && heat_call && ambient_sensor_fault
    && coil_cold && frost_cnt_reg >= 12'(FROST_S) |=> state_reg == ST_PRE)
    else $error("fallback defrost missed");
  standby_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_RUN && !heat_call && !cool_call
    |=> state_reg == ST_IDLE ##1 comp_speed == 8'h00)
    else $error("no shutdown after call ended");
  lamps_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    exv_stepping_open |=> exv_open_led)
    else $error("green lamp not lit");

  by_temp_c: cover property (@(posedge pclk) disable iff (!presetn)
    events[`EV_TERM_TEMP]);
  by_time_c: cover property (@(posedge pclk) disable iff (!presetn)
    events[`EV_TERM_TIME]);
  conv_run_c: cover property (@(posedge pclk) disable iff (!presetn)
    nominal_airflow_req && heating_reg);
  oil_done_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_OIL ##1 state_reg == ST_RUN);
endmodule : heat_pump_defrost_sequencer
`default_nettype wire

/* hvac_far_side_model.sv */
// Thermostat and indoor board model facing the defrost sequencer
`timescale 1ns/1ps
`default_nettype none
module hvac_far_side_model (
  input wire logic pclk,
  input wire logic want_heat,
  input wire logic want_cool,
  input wire logic aux_heat_req,
  output logic heat_call_input,
  output logic cool_stage_one_input,
  output logic cool_stage_two_input,
  output logic supp_heat_on
);
  // ****************************************
  // Thermostat calls and indoor answer
  // ****************************************
  always_ff @(posedge pclk) begin
    heat_call_input <= want_heat;
    cool_stage_one_input <= want_cool;
  end
  assign cool_stage_two_input = cool_stage_one_input;
  // Indoor heater follows the request one clock late
  always_ff @(posedge pclk) begin
    supp_heat_on <= aux_heat_req;
  end
endmodule : hvac_far_side_model
`default_nettype wire

/* heat_pump_defrost_sequencer_tb.sv */
// Self-checking bench for the heat pump defrost sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hp_defrost_defines.svh"
module heat_pump_defrost_sequencer_tb;
  import hp_defrost_pkg::*;
  // Short second keeps the long holds inside the run budget
  localparam int SC = 4;
  localparam int FAN = 0, RV = 1, DACT = 2, SW = 3, NOM = 4, OIL = 5, OFF = 6;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic want_heat, want_cool, hc, c1, c2, supp, b0, b1, fault, frost, hot;
  logic signed [7:0] coil, amb;
  logic eo, ec, lt, lr, rv, fan, exvo, aux, air, dact, led_o, led_c, tx, rx;
  logic [7:0] spd;
  logic [6:0] f;
  int err_count, checked, seed, n, r;

  hvac_far_side_model far_u (.pclk(pclk), .want_heat(want_heat),
    .want_cool(want_cool), .aux_heat_req(aux), .heat_call_input(hc),
    .cool_stage_one_input(c1), .cool_stage_two_input(c2),
    .supp_heat_on(supp));

  heat_pump_defrost_sequencer #(.SEC_CYCLES(SC)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .heat_call_input(hc), .cool_stage_one_input(c1),
    .cool_stage_two_input(c2), .term_temp_sel_bit0(b0),
    .term_temp_sel_bit1(b1), .coil_temp_sensor(coil),
    .ambient_temp_sensor(amb), .ambient_sensor_fault(fault),
    .frost_detected(frost), .discharge_hot(hot), .exv_stepping_open(eo),
    .exv_stepping_closed(ec), .link_tx_active(lt), .link_rx_active(lr),
    .comp_speed(spd), .reversing_valve(rv), .outdoor_fan_on(fan),
    .exv_full_open(exvo), .aux_heat_req(aux), .nominal_airflow_req(air),
    .defrost_active(dact), .exv_open_led(led_o), .exv_close_led(led_c),
    .link_tx_indicator(tx), .link_rx_indicator(rx), .irq(irq));

  always_comb f = {spd === 8'h00, spd === `SPD_OIL, spd === `SPD_NOMINAL,
    spd === `SPD_SWITCH, dact, rv, fan};

  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [7:0] term_f(input logic s0, input logic s1);
    case ({s1, s0})
      2'b00: return 8'd60;
      2'b01: return 8'd50;
      2'b10: return 8'd40;
      default: return 8'd70;
    endcase
  endfunction : term_f

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Bounded wait on one flag; n keeps the cycles spent
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    #1;
    while (f[i] !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(f[i], v);
  endtask : wt

  task automatic report_and_stop;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end

  // ****************************************
  // Stimulus and checks
  // ****************************************
  initial begin
    seed = 32'hf879add8;
    {psel, penable, pwrite, want_heat, want_cool, b0, b1} = '0;
    {fault, frost, hot, eo, ec, lt, lr} = '0;
    paddr = '0;
    pwdata = '0;
    coil = 8'sd20;
    amb = 8'sd25;
    err_count = 0;
    checked = 0;
    presetn = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    chk({spd, rv, fan, exvo, aux, dact, irq}, 0);
    apb(0, `REG_STATUS, 0);
    chk(rd, {16'h0, term_f(0, 0), 8'h00});
    apb(0, 12'hFFC, 0);
    chk({perr, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      {b1, b0} <= i[1:0];
      repeat (4) @(posedge pclk);
      apb(0, `REG_STATUS, 0);
      chk(rd[15:8], term_f(i[0], i[1]));
    end
    repeat (40) begin
      r = $random(seed);
      @(posedge pclk);
      {eo, ec, lt, lr} <= r[3:0];
      amb <= r[15:8];
      @(posedge pclk);
      #1;
      chk({led_o, led_c}, r[3:2]);
      chk({tx, rx}, r[1:0]);
    end
    apb(1, `REG_IRQ_MASK, 32'hF);
    @(posedge pclk);
    want_heat <= 1;
    wt(NOM, 1, 20);
    chk(air, 1);
    @(posedge pclk);
    hot <= 1;
    repeat (10 * SC) @(posedge pclk);
    hot <= 0;
    #1;
    chk(spd >= 8'h50 && spd <= 8'h60, 1);
    chk(irq, 1);
    wt(NOM, 1, 20 * SC);
    apb(1, `REG_IRQ_STAT, 32'hF);
    // Clear lands at this edge; look once it has settled
    #1;
    chk(irq, 0);
    apb(1, `REG_IRQ_MASK, 32'h1);
    // Cold coil alone must not start a cycle
    repeat (2100 * SC) @(posedge pclk);
    chk(dact, 0);
    apb(0, `REG_FROST_TIME, 0);
    chk(rd >= `FROST_RUN_S, 1);
    frost <= 1;
    wt(SW, 1, 10 * SC);
    wt(DACT, 1, 40 * SC);
    chk(n >= 29 * SC && n <= 31 * SC, 1);
    chk(irq, 1);
    repeat (2) @(posedge pclk);
    #1;
    chk({rv, exvo, fan}, 3'b010);
    chk({aux, supp}, 2'b11);
    chk(spd, `SPD_DEFROST);
    @(posedge pclk);
    coil <= 8'sd69;
    frost <= 0;
    repeat (20) @(posedge pclk);
    chk(dact, 1);
    coil <= 8'sd70;
    wt(DACT, 0, 10);
    apb(0, `REG_IRQ_STAT, 0);
    chk(rd[2:0], 3'b011);
    wt(SW, 1, 4);
    wt(RV, 1, 40 * SC);
    chk(n >= 28 * SC, 1);
    chk({fan, aux, exvo}, 3'b011);
    @(posedge pclk);
    #1;
    chk({fan, aux, exvo}, 3'b111);
    @(posedge pclk);
    #1;
    chk({fan, aux, exvo}, 3'b101);
    @(posedge pclk);
    #1;
    chk({fan, aux, exvo}, 3'b100);
    wt(OIL, 1, 4);
    wt(NOM, 1, 370 * SC);
    chk(n >= 355 * SC, 1);
    @(posedge pclk);
    fault <= 1;
    coil <= -8'sd5;
    wt(DACT, 1, 2200 * SC);
    chk(n >= 2000 * SC, 1);
    wt(DACT, 0, 850 * SC);
    chk(n >= 835 * SC, 1);
    apb(0, `REG_IRQ_STAT, 0);
    chk(rd[2], 1);
    // Call dropped in the post-defrost hold: sequence finishes first
    @(posedge pclk);
    want_heat <= 0;
    wt(OFF, 1, 420 * SC);
    chk(air, 0);
    @(posedge pclk);
    want_cool <= 1;
    wt(NOM, 1, 20);
    @(posedge pclk);
    want_cool <= 0;
    wt(OFF, 1, 20);
    // Communicating control: speed from the demand register
    apb(1, `REG_DEMAND, 32'h64);
    apb(1, `REG_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    #1;
    chk({spd, air}, {8'h64, 1'b0});
    apb(0, `REG_CTRL, 0);
    chk(rd, 32'h3);
    apb(1, `REG_CTRL, 32'h1);
    wt(OFF, 1, 20);
    report_and_stop();
  end
endmodule : heat_pump_defrost_sequencer_tb
`default_nettype wire
